// ===== rtl/evp_pkg.sv
// evp_pkg: constants for the exception vector and priority unit
// assumes: byte-addressed 16-bit vector table starting at address zero
package evp_pkg;
    localparam int EVP_NVEC = 21;                     // vector numbers 0..20
    localparam int EVP_VW = 5;                        // vector number width
    localparam logic [4:0] EVP_V_RESET = 5'h00;       // reset vector
    localparam logic [4:0] EVP_V_EXT_REQUEST_LINE_0 = 5'h04;        // request line 0 / low voltage
    localparam logic [4:0] EVP_V_EXT_REQUEST_LINE_1 = 5'h05;        // request line 1
    localparam logic [4:0] EVP_V_EVPIN = 5'h06;       // event counter pin
    localparam logic [4:0] EVP_V_WAKE = 5'h09;        // wakeup pins
    localparam logic [4:0] EVP_V_TMRA = 5'h0B;        // timer a overflow
    localparam logic [4:0] EVP_V_AEC = 5'h0C;         // async event counter
    localparam logic [4:0] EVP_V_TFL = 5'h0E;         // timer f low half
    localparam logic [4:0] EVP_V_TFH = 5'h0F;         // timer f high half
    localparam logic [4:0] EVP_V_SER = 5'h12;         // serial port unit
    localparam logic [4:0] EVP_V_ADC = 5'h13;         // conversion end
    localparam logic [4:0] EVP_V_DT = 5'h14;          // direct transition
    localparam logic [20:0] EVP_USER_MASK = 21'h1CDA70; // user vectors; reserved ones off
    localparam logic [15:0] EVP_RST_PC = 16'h0000;    // program counter at reset
    localparam logic [15:0] EVP_ADDR_ZERO = 16'h0000; // idle bus address
endpackage

// ===== rtl/evp_fetch_if.sv
// evp_fetch_if: vector word fetch link between sequencer and fetcher
// assumes: one clock, memory answers with a ready pulse
`timescale 1ns/10ps
`default_nettype none
interface evp_fetch_if;
    logic start;          // pulse: begin fetch
    logic [15:0] addr;    // vector entry address
    logic busy;           // fetch in progress
    logic done;           // pulse: pc valid
    logic [15:0] pc;      // fetched start address
    modport seq (output start, output addr, input busy, input done, input pc);
    modport fet (input start, input addr, output busy, output done, output pc);
endinterface
`default_nettype wire

// ===== rtl/evp_fetch.sv
// evp_fetch: reads the two-byte vector entry, high byte first
// assumes: memory gives read data one or more cycles after a request, with mem_ack
`timescale 1ns/10ps
`default_nettype none
module evp_fetch
    import evp_pkg::*;
(
    input wire logic mclk,            // system clock
    input wire logic rst_n,           // async reset, active low
    evp_fetch_if.fet fif,             // link to sequencer
    output logic mem_rd_nxt,          // read strobe to top register
    output logic [15:0] mem_addr_nxt, // byte address to top register
    input wire logic mem_ack,         // read data valid
    input wire logic [7:0] mem_rdata  // read byte
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] phase_r;   // 0 idle, 1 high byte, 2 low byte
    logic [7:0] hi_r;      // high byte hold
    logic [15:0] pc_r;     // fetched start address
    logic done_r;          // done pulse
    logic [15:0] base_r;   // entry address

    assign fif.busy = (phase_r != 2'h0);
    assign fif.done = done_r;
    assign fif.pc = pc_r;
    assign mem_rd_nxt = fif.start || (phase_r == 2'h1 && mem_ack);
    assign mem_addr_nxt = fif.start ? fif.addr : (base_r + 16'h0001);

    ////////////////////////////////////////////////////////////////
    // two sequential byte reads, then the start address pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r <= 2'h0;
            hi_r <= 8'h00;
            pc_r <= EVP_RST_PC;
            done_r <= 1'b0;
            base_r <= EVP_ADDR_ZERO;
        end
        else
        begin
            done_r <= 1'b0;
            if (fif.start)
            begin
                phase_r <= 2'h1;
                base_r <= fif.addr;
            end
            else if (phase_r == 2'h1 && mem_ack)
            begin
                hi_r <= mem_rdata;
                phase_r <= 2'h2;
            end
            else if (phase_r == 2'h2 && mem_ack)
            begin
                pc_r <= {hi_r, mem_rdata};
                done_r <= 1'b1;
                phase_r <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/evp_top.sv
// evp_top: exception entry logic, picks a vector and fetches its start address
// assumes: request lines are level flags synchronous to mclk, held by their source
`timescale 1ns/10ps
`default_nettype none
module evp_top
    import evp_pkg::*;
(
    input wire logic mclk,                   // system clock, 100 MHz
    input wire logic rst_n,                  // system reset, active low
    input wire logic external_reset_pin_n,   // reset pin, active low, asynchronous
    input wire logic wdt_overflow,           // watchdog overflow pulse
    input wire logic mask_i,                 // condition_code_register mask bit
    input wire logic insn_end,               // current instruction ends this cycle
    input wire logic ext_request_line_0,     // request line 0 flag
    input wire logic low_voltage_detector,   // low voltage detect flag
    input wire logic ext_request_line_1,     // request line 1 flag
    input wire logic event_counter_pin_request, // event counter pin flag
    input wire logic [7:0] wakeup_pins,      // wakeup_pin_first..wakeup_pin_last flags
    input wire logic timer_a_ovf,            // timer a overflow flag
    input wire logic aec_ovf,                // async event counter overflow flag
    input wire logic [1:0] timer_f_low_half, // compare match, overflow
    input wire logic [1:0] timer_f_high_half,// compare match, overflow
    input wire logic [3:0] serial_port_unit, // tx end, tx empty, tx full, rx error
    input wire logic adc_end,                // conversion end flag
    input wire logic direct_trans,           // direct transition flag
    input wire logic mem_ack,                // vector memory data valid
    input wire logic [7:0] mem_rdata,        // vector memory byte
    output logic mem_rd,                     // vector memory read strobe
    output logic [15:0] mem_addr,            // vector memory byte address
    output logic chip_reset,                 // internal chip reset, active high
    output logic exc_active,                 // exception handling under way
    output logic [4:0] exc_vector,           // vector being served
    output logic pc_load,                    // pulse: load pc
    output logic [15:0] pc_value             // start address for pc
);
    ////////////////////////////////////////////////////////////////
    // state machine
    typedef enum logic [1:0]
    {
        EVP_IDLE = 2'b00,   // running code
        EVP_RST = 2'b01,    // reset held
        EVP_FETCH = 2'b10,  // fetching vector entry
        EVP_WAIT = 2'b11    // fetch launched, waiting done
    } evp_state_e;

    evp_state_e state_r;     // current state
    evp_state_e state_nxt;   // next state
    logic pin_s1_r;          // reset pin sync stage 1
    logic pin_s2_r;          // reset pin sync stage 2
    logic wdt_r;             // watchdog overflow registered, one cycle later
    logic mem_rd_r;          // registered read strobe
    logic [15:0] mem_addr_r; // registered address
    logic chip_reset_r;      // chip reset output
    logic [4:0] vec_r;       // vector being served
    logic pc_load_r;         // pc load pulse
    logic [15:0] pc_r;       // pc value
    logic start_r;           // fetch start pulse
    logic exc_active_r;      // exception handling flag, mirrors fetch states
    logic mem_rd_nxt;        // from fetcher
    logic [15:0] mem_addr_nxt; // from fetcher

    evp_fetch_if fif();      // link to fetcher

    ////////////////////////////////////////////////////////////////
    // pending vector set, one bit per vector number
    function automatic logic [4:0] evp_pick(input logic [20:0] pend);
        logic [4:0] v;
        v = EVP_V_DT;
        for (int i = EVP_NVEC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                v = 5'(i);
            end
        end
        return v;
    endfunction

    // vector number to entry byte address
    function automatic logic [15:0] evp_addr(input logic [4:0] v);
        return {10'h000, v, 1'b0};
    endfunction

    wire [20:0] raw_pend;  // requests by vector number
    assign raw_pend[0] = 1'b0;
    assign raw_pend[3:1] = 3'h0;
    assign raw_pend[4] = ext_request_line_0 | low_voltage_detector;
    assign raw_pend[5] = ext_request_line_1;
    assign raw_pend[6] = event_counter_pin_request;
    assign raw_pend[8:7] = 2'h0;
    assign raw_pend[9] = |wakeup_pins;
    assign raw_pend[10] = 1'b0;
    assign raw_pend[11] = timer_a_ovf;
    assign raw_pend[12] = aec_ovf;
    assign raw_pend[13] = 1'b0;
    assign raw_pend[14] = |timer_f_low_half;
    assign raw_pend[15] = |timer_f_high_half;
    assign raw_pend[17:16] = 2'h0;
    assign raw_pend[18] = |serial_port_unit;
    assign raw_pend[19] = adc_end;
    assign raw_pend[20] = direct_trans;

    wire [20:0] pend = raw_pend & EVP_USER_MASK;
    wire any_req = (|pend) && !mask_i;
    wire [4:0] pick_vec = evp_pick(pend);
    // fetcher must be idle too, so a late done cannot overlap a new entry
    wire accept = any_req && insn_end && (state_r == EVP_IDLE) && !fif.busy;
    wire rst_req = !pin_s2_r || wdt_r;

    assign fif.start = start_r;
    assign fif.addr = evp_addr(vec_r);

    ////////////////////////////////////////////////////////////////
    // reset pin synchroniser
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= external_reset_pin_n;
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // next state; reset beats everything
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            EVP_RST: if (!rst_req) state_nxt = EVP_FETCH;
            EVP_IDLE: if (accept) state_nxt = EVP_FETCH;
            EVP_FETCH: state_nxt = EVP_WAIT;
            EVP_WAIT: if (fif.done) state_nxt = EVP_IDLE;
            default: state_nxt = EVP_RST;
        endcase
        if (rst_req)
        begin
            state_nxt = EVP_RST;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer registers; source flags are only read, never cleared
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= EVP_RST;
            wdt_r <= 1'b0;
            vec_r <= EVP_V_RESET;
            start_r <= 1'b0;
            chip_reset_r <= 1'b1;
            pc_load_r <= 1'b0;
            pc_r <= EVP_RST_PC;
            exc_active_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            wdt_r <= wdt_overflow;
            chip_reset_r <= (state_nxt == EVP_RST);
            start_r <= (state_nxt == EVP_FETCH);
            // registered copy of the fetch states keeps the output glitch free
            exc_active_r <= (state_nxt == EVP_FETCH) || (state_nxt == EVP_WAIT);
            pc_load_r <= (state_r == EVP_WAIT) && fif.done && !rst_req;
            if (fif.done)
            begin
                pc_r <= fif.pc;
            end
            if (state_r == EVP_RST)
            begin
                vec_r <= EVP_V_RESET;
            end
            else if (accept)
            begin
                vec_r <= pick_vec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // memory strobe and address registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_rd_r <= 1'b0;
            mem_addr_r <= EVP_ADDR_ZERO;
        end
        else
        begin
            mem_rd_r <= mem_rd_nxt;
            mem_addr_r <= mem_addr_nxt;
        end
    end

    evp_fetch u_fetch
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .fif(fif),
        .mem_rd_nxt(mem_rd_nxt),
        .mem_addr_nxt(mem_addr_nxt),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );

    assign mem_rd = mem_rd_r;
    assign mem_addr = mem_addr_r;
    assign chip_reset = chip_reset_r;
    assign exc_active = exc_active_r;
    assign exc_vector = vec_r;
    assign pc_load = pc_load_r;
    assign pc_value = pc_r;
endmodule
`default_nettype wire

// ===== tb/evp_properties.sv
// evp_properties: port-level checks of the exception unit
// assumes: one mclk domain, rst_n async active low
`timescale 1ns/10ps
`default_nettype none
module evp_chk
    import evp_pkg::*;
(
    input wire logic mclk, rst_n, // clock, reset
    input wire logic external_reset_pin_n, wdt_overflow, mask_i, insn_end, // control
    input wire logic ext_request_line_0, low_voltage_detector, ext_request_line_1, // pins
    input wire logic event_counter_pin_request, timer_a_ovf, aec_ovf, // flags
    input wire logic adc_end, direct_trans, // flags
    input wire logic [7:0] wakeup_pins, // wakeup flags
    input wire logic [1:0] timer_f_low_half, timer_f_high_half, // timer f flags
    input wire logic [3:0] serial_port_unit, // serial flags
    input wire logic mem_rd, chip_reset, exc_active, pc_load, // outputs
    input wire logic [15:0] mem_addr, // fetch address
    input wire logic [4:0] exc_vector // served vector
);
    logic [20:0] pend; // pending vector numbers
    logic [4:0] top_v; // lowest pending vector
    assign pend = {direct_trans, adc_end, |serial_port_unit, 2'h0, |timer_f_high_half,
        |timer_f_low_half, 1'h0, aec_ovf, timer_a_ovf, 1'h0, |wakeup_pins, 2'h0,
        event_counter_pin_request, ext_request_line_1,
        ext_request_line_0 | low_voltage_detector, 4'h0};
    // lowest set index wins
    always_comb
    begin
        top_v = 5'h00;
        for (int i = 20; i > 0; i--)
            if (pend[i]) top_v = 5'(i);
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_pin_reset:
        assert property (!external_reset_pin_n |-> ##[0:3] chip_reset) else $error("no pin reset");
    chk_wdt_reset:
        assert property (wdt_overflow |-> ##[0:3] chip_reset) else $error("no watchdog reset");
    chk_reset_vec:
        assert property ($fell(chip_reset) |-> ##[0:3] exc_active && exc_vector == EVP_V_RESET)
        else $error("reset vector not fetched");
    chk_mask_holds:
        assert property ($rose(exc_active) && exc_vector != EVP_V_RESET |-> !$past(mask_i))
        else $error("masked request taken");
    chk_accept_end:
        assert property ($rose(exc_active) && exc_vector != EVP_V_RESET |-> $past(insn_end))
        else $error("request taken mid instruction");
    chk_pick_top:
        assert property ($rose(exc_active) && exc_vector != EVP_V_RESET
            |-> exc_vector == $past(top_v)) else $error("wrong vector chosen");
    chk_vec_legal:
        assert property (exc_active |-> exc_vector == EVP_V_RESET || EVP_USER_MASK[exc_vector])
        else $error("reserved vector used");
    chk_fetch_addr:
        assert property (mem_rd |-> mem_addr[15:1] == {10'h000, exc_vector})
        else $error("fetch address off entry");
    chk_fetch_ends:
        assert property ($rose(exc_active) |-> ##[3:60] pc_load) else $error("fetch never ends");
    chk_vec_steady:
        assert property (exc_active && $past(exc_active) |-> $stable(exc_vector))
        else $error("vector changed mid fetch");
    cover property ($rose(exc_active) && exc_vector == EVP_V_DT);
    cover property (mask_i && insn_end && |pend);
    cover property (pc_load && exc_vector == EVP_V_RESET);
endmodule
bind evp_top evp_chk u_chk (.mclk, .rst_n, .external_reset_pin_n, .wdt_overflow, .mask_i,
    .insn_end, .ext_request_line_0, .low_voltage_detector, .ext_request_line_1,
    .event_counter_pin_request, .timer_a_ovf, .aec_ovf, .adc_end, .direct_trans, .wakeup_pins,
    .timer_f_low_half, .timer_f_high_half, .serial_port_unit, .mem_rd, .chip_reset,
    .exc_active, .pc_load, .mem_addr, .exc_vector);
`default_nettype wire

// ===== tb/evp_mem_model.sv
// evp_mem_model: vector table memory behind the fetch port
// assumes: one read strobe per byte, answer after lat idle cycles
`timescale 1ns/10ps
`default_nettype none
module evp_mem_model (
    input wire logic mclk, // clock
    input wire logic rst_n, // reset
    input wire logic mem_rd, // read strobe
    input wire logic [15:0] mem_addr, // byte address
    input wire logic [3:0] lat, // answer delay
    output logic mem_ack, // data valid
    output logic [7:0] mem_rdata // read byte
);
    logic pend_r; // read outstanding
    logic [3:0] cnt_r; // cycles left
    logic [7:0] addr_r; // latched address
    // byte at a is a xor 5A; data toggles while not answering
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_r <= 1'b0;
            cnt_r <= 4'h0;
            addr_r <= 8'h00;
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_rd)
            begin
                pend_r <= 1'b1;
                cnt_r <= lat;
                addr_r <= mem_addr[7:0];
            end
            else if (pend_r && cnt_r == 4'h0)
            begin
                pend_r <= 1'b0;
                mem_ack <= 1'b1;
                mem_rdata <= addr_r ^ 8'h5A;
            end
            else if (pend_r)
                cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_exception_vector_priority.sv
// tb_exception_vector_priority: directed bench for the exception unit
// assumes: evp_mem_model serves vector bytes
`timescale 1ns/10ps
`default_nettype none
module tb_exception_vector_priority;
    import evp_pkg::*;
    logic mclk, rst_n, pin_n, wdt, mask, iend; // clock, resets, control
    logic [23:0] req; // request flags
    logic mem_rd, mem_ack, chip_reset, exc_active, pc_load; // handshakes
    logic [7:0] mem_rdata; // memory byte
    logic [15:0] mem_addr, pc_value; // address, start address
    logic [4:0] exc_vector; // served vector
    logic [3:0] lat; // memory delay
    int errors, num_checks; // counters
    // vector of each request bit
    localparam logic [4:0] vec_tab [24] = '{5'h04, 5'h04, 5'h05, 5'h06, 5'h09, 5'h09, 5'h09,
        5'h09, 5'h09, 5'h09, 5'h09, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h12,
        5'h12, 5'h12, 5'h12, 5'h13, 5'h14};
    evp_top u_dut (.mclk, .rst_n, .external_reset_pin_n(pin_n), .wdt_overflow(wdt),
        .mask_i(mask), .insn_end(iend), .ext_request_line_0(req[0]),
        .low_voltage_detector(req[1]), .ext_request_line_1(req[2]),
        .event_counter_pin_request(req[3]), .wakeup_pins(req[11:4]), .timer_a_ovf(req[12]),
        .aec_ovf(req[13]), .timer_f_low_half(req[15:14]), .timer_f_high_half(req[17:16]),
        .serial_port_unit(req[21:18]), .adc_end(req[22]), .direct_trans(req[23]), .mem_ack,
        .mem_rdata, .mem_rd, .mem_addr, .chip_reset, .exc_active, .exc_vector, .pc_load,
        .pc_value);
    evp_mem_model u_mem (.mclk, .rst_n, .mem_rd, .mem_addr, .lat, .mem_ack, .mem_rdata);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] exp_pc(input logic [4:0] v);
        return {8'({v, 1'b0}) ^ 8'h5A, 8'({v, 1'b1}) ^ 8'h5A};
    endfunction
    // wait for the pc load pulse, then judge vector and start address
    task automatic wait_load(input logic [4:0] v);
        int n;
        n = 0;
        while (pc_load !== 1'b1)
        begin
            @(negedge mclk);
            n++;
            if (n > 80)
            begin
                errors++;
                test_done();
            end
        end
        check("vector", 16'(v), 16'(exc_vector));
        check("start address", exp_pc(v), pc_value);
    endtask
    task automatic serve(input logic [4:0] v);
        @(negedge mclk);
        iend = 1'b1;
        @(negedge mclk);
        iend = 1'b0;
        wait_load(v);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_mask();
        req = 24'h001000;
        for (int c = 0; c < 8; c++)
        begin
            mask = (c < 4);
            iend = (c < 4);
            @(negedge mclk);
            check("exc active", 16'h0000, 16'(exc_active));
        end
        serve(5'h0B);
        req = 24'h0;
    endtask
    task automatic t_single();
        for (int i = 0; i < 24; i++)
        begin
            lat = 4'(i % 4);
            req = 24'h1 << i;
            serve(vec_tab[i]);
            req = 24'h0;
        end
    endtask
    task automatic t_priority();
        logic [4:0] v;
        req = 24'hFFFFFF;
        while (req != 24'h0)
        begin
            v = 5'h1F;
            for (int i = 0; i < 24; i++)
                if (req[i] && vec_tab[i] < v) v = vec_tab[i];
            serve(v);
            for (int i = 0; i < 24; i++)
                if (vec_tab[i] == v) req[i] = 1'b0;
        end
    endtask
    // pending requests must lose to a pin or watchdog reset
    task automatic t_reset(input int k);
        req = 24'h800001;
        if (k == 0) pin_n = 1'b0;
        else wdt = 1'b1;
        repeat (4) @(negedge mclk);
        check("chip reset", 16'h0001, 16'(chip_reset));
        pin_n = 1'b1;
        wdt = 1'b0;
        wait_load(EVP_V_RESET);
        req = 24'h0;
    endtask
    initial
    begin
        rst_n = 1'b0;
        pin_n = 1'b0;
        wdt = 1'b0;
        mask = 1'b1;
        iend = 1'b0;
        req = 24'h0;
        lat = 4'h0;
        errors = 0;
        num_checks = 0;
        repeat (16) @(negedge mclk);
        check("chip reset", 16'h0001, 16'(chip_reset));
        rst_n = 1'b1;
        pin_n = 1'b1;
        wait_load(EVP_V_RESET);
        t_mask();
        t_single();
        lat = 4'h3;
        t_priority();
        t_reset(0);
        t_reset(1);
        test_done();
    end
endmodule
`default_nettype wire
